// ==== core/pcis_par_chk.sv ====
// odd parity check on one transmit character
`timescale 1ns/1ps
module pcis_par_chk (
	// selection
	input wire pcis_pkg::pcis_level_t par_ctl_i,
	input wire logic enc_on_i,
	// character
	input wire pcis_pkg::pcis_tx_char_t ch_i,
	// result
	output logic err_o
);
	wire full_w = (par_ctl_i == pcis_pkg::LVL_HIGH) || !enc_on_i; // R01 R03
	wire data_only_w = (par_ctl_i == pcis_pkg::LVL_MID) && enc_on_i; // R09
	wire p_full_w = ^{ch_i.bits, ch_i.ctype, ch_i.par};
	wire p_data_w = ^{ch_i.bits, ch_i.par};
	wire checking_w = par_ctl_i != pcis_pkg::LVL_LOW; // R08

	// an odd-parity group xors to one, so zero is an error
	assign err_o = checking_w &&
		((full_w && !p_full_w) || (data_only_w && !p_data_w));
endmodule

// ==== core/pcis_par_gen.sv ====
// odd parity generation for one receive character
`timescale 1ns/1ps
module pcis_par_gen (
	// selection
	input wire pcis_pkg::pcis_level_t par_ctl_i,
	input wire logic dec_on_i,
	// character
	input wire pcis_pkg::pcis_rx_char_t ch_i,
	// result
	output logic par_o,
	output logic oe_o
);
	wire full_w = (par_ctl_i == pcis_pkg::LVL_HIGH) || !dec_on_i; // R02 R03
	assign par_o = full_w ? ~^{ch_i.bits, ch_i.status} : ~^ch_i.bits; // R09
	assign oe_o = par_ctl_i != pcis_pkg::LVL_LOW; // R08
endmodule

// ==== core/pcis_pkg.sv ====
// shared constants and types for the parity and clock select block
package pcis_pkg;

	localparam int NUM_CH = 4;

	// three-level select encodings
	typedef enum logic [1:0] {
		LVL_LOW  = 2'h0,
		LVL_MID  = 2'h1,
		LVL_HIGH = 2'h2
	} pcis_level_t;

	// register byte offsets
	localparam logic [7:0] OFS_CTRL   = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_MASK   = 8'h08;
	localparam logic [7:0] OFS_RATE   = 8'h0c;

	// control register field positions
	localparam int CTRL_PAR_LSB = 0;
	localparam int CTRL_RATE_LSB = 2;
	localparam int CTRL_TXCK_BIT = 4;
	localparam int CTRL_RXCK_BIT = 5;
	localparam int CTRL_INSEL_LSB = 8;

	// reset values
	localparam logic [31:0] CTRL_RST = 32'h0000_0f00;
	localparam logic [3:0] MASK_RST = 4'h0;

	// rate ranges in megabaud, reported back on the rate register
	localparam logic [15:0] RATE_LOW_MIN = 16'd200;
	localparam logic [15:0] RATE_LOW_MAX = 16'd400;
	localparam logic [15:0] RATE_MID_MAX = 16'd800;
	localparam logic [15:0] RATE_HIGH_MAX = 16'd1500;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// transmit character as offered by the host
	typedef struct packed {
		logic [7:0] bits;
		logic [1:0] ctype;
		logic par;
	} pcis_tx_char_t;

	// receive character as offered to the host
	typedef struct packed {
		logic [7:0] bits;
		logic [2:0] status;
	} pcis_rx_char_t;

endpackage

// ==== core/pcis_top.sv ====
// parity check/generate, clock and serial input selection with axi4-lite
// How it works
// (R01) at high parity control with the encoder on, tx data, type and parity bits are checked for odd parity.
// (R02) at high parity control the rx parity output is odd parity over rx data and the three status bits.
// (R03) with encoder and decoder bypassed and parity on, the same full checks and generation still apply.
// (R04) the rate range select sets both pll ranges 200-400, 400-800 or 800-1500 megabaud and is held static.
// (R05) with tx interface clock select low, tx characters are registered on the reference clock.
// (R06) with rx interface clock select low, rx characters leave from the reference clock domain.
// (R07) each channel passes its primary serial input when its select is high, otherwise the secondary.
// (R08) at low parity control nothing is checked and every rx parity output is released.
// (R09) at mid parity control with coding on, only the data bits take part in check and generation.
// (R10) a failed tx parity check marks the character erroneous, visible to the host per channel.
`timescale 1ns/1ps
module pcis_top (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// axi4-lite write address
	input wire logic [7:0] s_awaddr_i,
	input wire logic s_awvalid_i,
	output logic s_awready_o,
	// axi4-lite write data
	input wire logic [31:0] s_wdata_i,
	input wire logic [3:0] s_wstrb_i,
	input wire logic s_wvalid_i,
	output logic s_wready_o,
	// axi4-lite write response
	output logic [1:0] s_bresp_o,
	output logic s_bvalid_o,
	input wire logic s_bready_i,
	// axi4-lite read address
	input wire logic [7:0] s_araddr_i,
	input wire logic s_arvalid_i,
	output logic s_arready_o,
	// axi4-lite read data
	output logic [31:0] s_rdata_o,
	output logic [1:0] s_rresp_o,
	output logic s_rvalid_o,
	input wire logic s_rready_i,
	// interface clock enables
	input wire logic tx_iface_clk_en_i,
	input wire logic rx_iface_clk_en_i,
	// mode selects for encoder and decoder, bit 1 low means bypass
	input wire logic [1:0] tx_mode_select_i,
	input wire logic [1:0] rx_mode_select_i,
	// transmit characters from host, one per channel
	input wire pcis_pkg::pcis_tx_char_t [3:0] tx_char_i,
	// receive characters from the decoder, one per channel
	input wire pcis_pkg::pcis_rx_char_t [3:0] rx_char_i,
	// serial front ends
	input wire logic [3:0] primary_serial_in_i,
	input wire logic [3:0] secondary_serial_in_i,
	output logic [3:0] cdr_serial_o,
	// registered transmit characters toward the encoder
	output pcis_pkg::pcis_tx_char_t [3:0] tx_char_o,
	output logic [3:0] tx_char_err_o,
	// receive characters to host
	output logic [3:0][7:0] rx_char_bits_o,
	output logic [3:0][2:0] rx_status_bits_o,
	output logic [3:0] rx_parity_bit_o,
	output logic [3:0] rx_parity_oe_o,
	// pll range and interrupt
	output pcis_pkg::pcis_level_t rate_range_select_o,
	output logic irq_o
);
	logic [31:0] ctrl_r;
	logic [3:0] status_r;
	logic [3:0] mask_r;
	logic aw_got_r, w_got_r;
	logic [7:0] awaddr_r;
	logic [31:0] wdata_r;
	logic [3:0] wstrb_r;
	logic bvalid_r;
	logic [1:0] bresp_r;
	logic rvalid_r;
	logic [31:0] rdata_r;
	logic [1:0] rresp_r;
	pcis_pkg::pcis_tx_char_t [3:0] tx_q_r;
	logic [3:0] tx_err_r;
	logic [3:0][7:0] rxb_r;
	logic [3:0][2:0] rxs_r;
	logic [3:0] rxp_r;
	logic [3:0] rxoe_r;

	// control fields
	wire [1:0] par_raw_w = ctrl_r[pcis_pkg::CTRL_PAR_LSB +: 2];
	wire [1:0] rate_raw_w = ctrl_r[pcis_pkg::CTRL_RATE_LSB +: 2];
	wire pcis_pkg::pcis_level_t par_ctl_w = (par_raw_w == 2'h3) ?
		pcis_pkg::LVL_HIGH : pcis_pkg::pcis_level_t'(par_raw_w);
	wire pcis_pkg::pcis_level_t rate_w = (rate_raw_w == 2'h3) ?
		pcis_pkg::LVL_HIGH : pcis_pkg::pcis_level_t'(rate_raw_w);
	wire tx_ck_sel_w = ctrl_r[pcis_pkg::CTRL_TXCK_BIT];
	wire rx_ck_sel_w = ctrl_r[pcis_pkg::CTRL_RXCK_BIT];
	wire [3:0] insel_w = ctrl_r[pcis_pkg::CTRL_INSEL_LSB +: 4];
	wire enc_on_w = tx_mode_select_i[1];
	wire dec_on_w = rx_mode_select_i[1];

	// reference clock is clk_i itself, so low select means every cycle
	wire tx_take_w = !tx_ck_sel_w || tx_iface_clk_en_i; // R05
	wire rx_take_w = !rx_ck_sel_w || rx_iface_clk_en_i; // R06

	assign cdr_serial_o = (insel_w & primary_serial_in_i) |
		(~insel_w & secondary_serial_in_i); // R07
	assign rate_range_select_o = rate_w; // R04

	// per-channel parity blocks
	logic [3:0] chk_err_w;
	logic [3:0] gen_par_w;
	logic [3:0] gen_oe_w;
	genvar g;
	generate
		for (g = 0; g < pcis_pkg::NUM_CH; g++) begin : g_ch
			pcis_par_chk u_chk (
				.par_ctl_i(par_ctl_w),
				.enc_on_i(enc_on_w),
				.ch_i(tx_char_i[g]),
				.err_o(chk_err_w[g])
			);
			pcis_par_gen u_gen (
				.par_ctl_i(par_ctl_w),
				.dec_on_i(dec_on_w),
				.ch_i(rx_char_i[g]),
				.par_o(gen_par_w[g]),
				.oe_o(gen_oe_w[g])
			);
		end
	endgenerate

	// datapath registers
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			tx_q_r <= '0;
			tx_err_r <= 4'h0;
		end else if (tx_take_w) begin
			tx_q_r <= tx_char_i;
			tx_err_r <= chk_err_w; // R10
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rxb_r <= '0;
			rxs_r <= '0;
			rxp_r <= 4'h0;
			rxoe_r <= 4'h0;
		end else if (rx_take_w) begin
			for (int i = 0; i < pcis_pkg::NUM_CH; i++) begin
				rxb_r[i] <= rx_char_i[i].bits;
				rxs_r[i] <= rx_char_i[i].status;
			end
			rxp_r <= gen_par_w; // R02
			rxoe_r <= gen_oe_w; // R08
		end
	end

	assign tx_char_o = tx_q_r;
	assign tx_char_err_o = tx_err_r;
	assign rx_char_bits_o = rxb_r;
	assign rx_status_bits_o = rxs_r;
	assign rx_parity_bit_o = rxp_r;
	assign rx_parity_oe_o = rxoe_r;

	// axi4-lite write side
	wire wr_go_w = aw_got_r && w_got_r && !bvalid_r;
	wire wr_ctrl_w = wr_go_w && awaddr_r == pcis_pkg::OFS_CTRL;
	wire wr_stat_w = wr_go_w && awaddr_r == pcis_pkg::OFS_STATUS;
	wire wr_mask_w = wr_go_w && awaddr_r == pcis_pkg::OFS_MASK;
	wire wr_ok_w = wr_ctrl_w || wr_stat_w || wr_mask_w;
	wire [31:0] bmask_w = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}},
		{8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
	wire [3:0] w1c_w = (wr_stat_w && wstrb_r[0]) ? wdata_r[3:0] : 4'h0;
	// a new error in the clearing cycle stays set
	wire [3:0] tx_err_ev_w = tx_take_w ? chk_err_w : 4'h0; // R10
	wire [3:0] status_nxt = (status_r & ~w1c_w) | tx_err_ev_w; // R10

	assign s_awready_o = !aw_got_r;
	assign s_wready_o = !w_got_r;
	assign s_bvalid_o = bvalid_r;
	assign s_bresp_o = bresp_r;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			aw_got_r <= 1'b0;
			w_got_r <= 1'b0;
			awaddr_r <= 8'h00;
			wdata_r <= 32'h0000_0000;
			wstrb_r <= 4'h0;
		end else begin
			if (s_awvalid_i && !aw_got_r) begin
				aw_got_r <= 1'b1;
				awaddr_r <= s_awaddr_i;
			end else if (wr_go_w) begin
				aw_got_r <= 1'b0;
			end
			if (s_wvalid_i && !w_got_r) begin
				w_got_r <= 1'b1;
				wdata_r <= s_wdata_i;
				wstrb_r <= s_wstrb_i;
			end else if (wr_go_w) begin
				w_got_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			bvalid_r <= 1'b0;
			bresp_r <= pcis_pkg::RESP_OKAY;
		end else if (wr_go_w) begin
			bvalid_r <= 1'b1;
			bresp_r <= wr_ok_w ? pcis_pkg::RESP_OKAY : pcis_pkg::RESP_SLVERR;
		end else if (s_bready_i) begin
			bvalid_r <= 1'b0;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ctrl_r <= pcis_pkg::CTRL_RST;
			mask_r <= pcis_pkg::MASK_RST;
			status_r <= 4'h0;
		end else begin
			if (wr_ctrl_w)
				ctrl_r <= (ctrl_r & ~bmask_w) | (wdata_r & bmask_w);
			if (wr_mask_w && wstrb_r[0])
				mask_r <= wdata_r[3:0];
			status_r <= status_nxt;
		end
	end

	assign irq_o = |(status_r & mask_r);

	// axi4-lite read side
	wire [31:0] rate_info_w = (rate_w == pcis_pkg::LVL_LOW) ?
		{pcis_pkg::RATE_LOW_MAX, pcis_pkg::RATE_LOW_MIN} :
		(rate_w == pcis_pkg::LVL_MID) ?
		{pcis_pkg::RATE_MID_MAX, pcis_pkg::RATE_LOW_MAX} :
		{pcis_pkg::RATE_HIGH_MAX, pcis_pkg::RATE_MID_MAX}; // R04
	wire rd_ctrl_w = s_araddr_i == pcis_pkg::OFS_CTRL;
	wire rd_stat_w = s_araddr_i == pcis_pkg::OFS_STATUS;
	wire rd_mask_w = s_araddr_i == pcis_pkg::OFS_MASK;
	wire rd_rate_w = s_araddr_i == pcis_pkg::OFS_RATE;
	wire rd_ok_w = rd_ctrl_w || rd_stat_w || rd_mask_w || rd_rate_w;
	wire [31:0] rd_val_w = rd_ctrl_w ? (ctrl_r & 32'h0000_0f3f) :
		rd_stat_w ? {28'h0, status_r} :
		rd_mask_w ? {28'h0, mask_r} :
		rd_rate_w ? rate_info_w : 32'h0000_0000;

	assign s_arready_o = !rvalid_r;
	assign s_rvalid_o = rvalid_r;
	assign s_rdata_o = rdata_r;
	assign s_rresp_o = rresp_r;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rvalid_r <= 1'b0;
			rdata_r <= 32'h0000_0000;
			rresp_r <= pcis_pkg::RESP_OKAY;
		end else if (s_arvalid_i && !rvalid_r) begin
			rvalid_r <= 1'b1;
			rdata_r <= rd_val_w;
			rresp_r <= rd_ok_w ? pcis_pkg::RESP_OKAY : pcis_pkg::RESP_SLVERR;
		end else if (s_rready_i) begin
			rvalid_r <= 1'b0;
		end
	end

endmodule

// ==== verification/pcis_host_model.sv ====
// host model offering transmit and receive characters
`timescale 1ns/1ps
module pcis_host_model (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// commands
	input wire logic go_i,
	input wire logic full_i,
	input wire logic [3:0] bad_i,
	// characters toward the block
	output pcis_pkg::pcis_tx_char_t [3:0] tx_char_o,
	output pcis_pkg::pcis_rx_char_t [3:0] rx_char_o
);
	logic [31:0] t;
	logic p;
	// odd parity over the chosen group unless a channel is told otherwise
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			tx_char_o <= '0;
			rx_char_o <= '0;
		end else if (go_i) begin
			for (int c = 0; c < 4; c++) begin
				t = $urandom;
				p = full_i ? ~^t[9:0] : ~^t[9:2];
				tx_char_o[c] <= {t[9:0], p ^ bad_i[c]};
				rx_char_o[c] <= t[20:10];
			end
		end
	end
endmodule

// ==== verification/pcis_properties.sv ====
// assertion checker for the parity and clock select block
`timescale 1ns/1ps
module pcis_chk (
	// clock, reset and bus handshakes
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic s_awvalid_i,
	input wire logic s_awready_o,
	input wire logic s_wvalid_i,
	input wire logic s_wready_o,
	input wire logic s_bvalid_o,
	input wire logic s_bready_i,
	input wire logic s_arvalid_i,
	input wire logic s_arready_o,
	input wire logic s_rvalid_o,
	input wire logic s_rready_i,
	// character paths
	input wire pcis_pkg::pcis_tx_char_t [3:0] tx_char_i,
	input wire pcis_pkg::pcis_tx_char_t [3:0] tx_char_o,
	input wire logic [3:0] tx_char_err_o,
	input wire pcis_pkg::pcis_rx_char_t [3:0] rx_char_i,
	input wire logic [3:0][7:0] rx_char_bits_o,
	input wire logic [3:0][2:0] rx_status_bits_o,
	input wire logic [3:0] rx_parity_bit_o,
	input wire logic [3:0] rx_parity_oe_o,
	// serial routing and rate
	input wire logic [3:0] primary_serial_in_i,
	input wire logic [3:0] secondary_serial_in_i,
	input wire logic [3:0] cdr_serial_o,
	input wire pcis_pkg::pcis_level_t rate_range_select_o
);
	wire [3:0] route_ok = ~(cdr_serial_o ^ primary_serial_in_i) |
		~(cdr_serial_o ^ secondary_serial_in_i);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	chk_rate_coded: assert property (rate_range_select_o != 2'h3)
		else $error("rate code 3");
	chk_input_route: assert property (&route_ok)
		else $error("serial input not routed");
	chk_wr_answer: assert property (s_awvalid_i && s_awready_o &&
		s_wvalid_i && s_wready_o |-> ##[1:2] s_bvalid_o)
		else $error("write response late");
	chk_rd_answer: assert property (s_arvalid_i && s_arready_o |=>
		s_rvalid_o) else $error("read data late");
	chk_b_retire: assert property (s_bvalid_o && s_bready_i |=>
		!s_bvalid_o) else $error("write response repeated");
	chk_r_retire: assert property (s_rvalid_o && s_rready_i |=>
		!s_rvalid_o) else $error("read data repeated");
	chk_tx_follow: assert property (!$stable(tx_char_o) |->
		tx_char_o == $past(tx_char_i)) else $error("tx char not from input");
	for (genvar c = 0; c < 4; c++) begin : g_ch
		chk_rx_odd: assert property (rx_parity_oe_o[c] |->
			rx_parity_bit_o[c] == ~^rx_char_bits_o[c] ||
			rx_parity_bit_o[c] == ~^{rx_char_bits_o[c], rx_status_bits_o[c]})
			else $error("rx parity not odd");
		chk_err_even: assert property (tx_char_err_o[c] |->
			!(^{tx_char_o[c].bits, tx_char_o[c].par}) || !(^tx_char_o[c]))
			else $error("error flag on odd char");
		chk_rx_follow: assert property (!$stable(rx_char_bits_o[c]) |->
			rx_char_bits_o[c] == $past(rx_char_i[c].bits))
			else $error("rx char not from input");
	end
endmodule

bind pcis_top pcis_chk pcis_chk_inst (.*);

// ==== verification/testbench.sv ====
// self-checking bench for the parity and clock select block
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin \
	err_total++; $display("[ERR] %0t mismatch", $time); end end
module testbench;
	logic clk_i = 1'b0;
	logic rst_n_i, s_awvalid_i, s_wvalid_i, s_bready_i, s_arvalid_i;
	logic s_rready_i, tx_iface_clk_en_i, rx_iface_clk_en_i, go_i, full_i;
	logic [7:0] s_awaddr_i, s_araddr_i;
	logic [31:0] s_wdata_i, s_rdata_o;
	logic [3:0] s_wstrb_i, primary_serial_in_i, secondary_serial_in_i, bad_i;
	logic [3:0] cdr_serial_o, tx_char_err_o, rx_parity_bit_o, rx_parity_oe_o;
	logic [1:0] tx_mode_select_i, rx_mode_select_i, s_bresp_o, s_rresp_o;
	logic s_awready_o, s_wready_o, s_bvalid_o, s_arready_o, s_rvalid_o, irq_o;
	pcis_pkg::pcis_tx_char_t [3:0] tx_char_i, tx_char_o;
	pcis_pkg::pcis_rx_char_t [3:0] rx_char_i;
	logic [3:0][7:0] rx_char_bits_o;
	logic [3:0][2:0] rx_status_bits_o;
	pcis_pkg::pcis_level_t rate_range_select_o;
	logic [3:0] sel;
	int err_total = 0;
	int n_checks = 0;

	pcis_top pcis_top_inst (.*);
	pcis_host_model pcis_host_model_inst (.clk_i, .rst_n_i, .go_i, .full_i,
		.bad_i, .tx_char_o(tx_char_i), .rx_char_o(rx_char_i));

	always #12.5 clk_i = ~clk_i;

	task automatic report_and_stop();
		if (err_total == 0 && n_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] e);
		s_awaddr_i <= a;
		s_wdata_i <= d;
		s_wstrb_i <= 4'hf;
		{s_awvalid_i, s_wvalid_i, s_bready_i} <= 3'h7;
		@(posedge clk_i);
		while (s_awvalid_i || s_wvalid_i || s_bready_i) begin
			if (s_awready_o) s_awvalid_i <= 1'b0;
			if (s_wready_o) s_wvalid_i <= 1'b0;
			if (s_bvalid_o) begin
				s_bready_i <= 1'b0;
				`CHK(s_bresp_o, e)
			end
			@(posedge clk_i);
		end
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] e);
		s_araddr_i <= a;
		{s_arvalid_i, s_rready_i} <= 2'h3;
		@(posedge clk_i);
		while (s_arvalid_i || s_rready_i) begin
			if (s_arready_o) s_arvalid_i <= 1'b0;
			if (s_rvalid_o) begin
				s_rready_i <= 1'b0;
				`CHK(s_rdata_o, d)
				`CHK(s_rresp_o, e)
			end
			@(posedge clk_i);
		end
	endtask

	// new characters from the host model, then let them settle
	task automatic step(input logic [3:0] b);
		bad_i <= b;
		go_i <= 1'b1;
		@(posedge clk_i);
		go_i <= 1'b0;
		repeat (3) @(posedge clk_i);
	endtask

	function automatic logic exp_err(int l, logic m,
		pcis_pkg::pcis_tx_char_t t);
		if (l == 0) return 1'b0;
		if (l == 1 && m) return ~^{t.bits, t.par};
		return ~^t;
	endfunction

	function automatic logic exp_par(int l, logic m,
		pcis_pkg::pcis_rx_char_t r);
		if (l == 1 && m) return ~^r.bits;
		return ~^r;
	endfunction

	function automatic logic [31:0] exp_rate(int l);
		if (l == 0) return 32'h0190_00c8;
		if (l == 1) return 32'h0320_0190;
		return 32'h05dc_0320;
	endfunction

	initial begin
		repeat (5000) @(posedge clk_i);
		err_total++;
		report_and_stop();
	end

	initial begin
		{rst_n_i, s_awvalid_i, s_wvalid_i, s_bready_i, s_arvalid_i} = '0;
		{s_rready_i, tx_iface_clk_en_i, rx_iface_clk_en_i, go_i, full_i} = '0;
		{s_awaddr_i, s_araddr_i, s_wdata_i, s_wstrb_i, bad_i} = '0;
		{primary_serial_in_i, secondary_serial_in_i} = '0;
		{tx_mode_select_i, rx_mode_select_i} = '0;
		void'($urandom(43));
		repeat (3) @(posedge clk_i);
		rst_n_i <= 1'b1;
		rd(pcis_pkg::OFS_CTRL, 32'h0000_0f00, pcis_pkg::RESP_OKAY);
		rd(pcis_pkg::OFS_MASK, 32'h0, pcis_pkg::RESP_OKAY);
		rd(8'h10, 32'h0, pcis_pkg::RESP_SLVERR);
		wr(pcis_pkg::OFS_RATE, 32'h0, pcis_pkg::RESP_SLVERR);
		for (int l = 0; l < 3; l++) begin
			for (int m = 0; m < 2; m++) begin
				sel = $urandom;
				wr(pcis_pkg::OFS_CTRL, {20'h0, sel, 4'h0, l[1:0], l[1:0]},
					pcis_pkg::RESP_OKAY);
				{tx_mode_select_i, rx_mode_select_i} <= {m[0], 1'b1, m[0], 1'b0};
				full_i <= !(l == 1 && m == 1);
				primary_serial_in_i <= $urandom;
				secondary_serial_in_i <= $urandom;
				repeat (6) begin
					step($urandom);
					for (int c = 0; c < 4; c++) begin
						`CHK(tx_char_o[c], tx_char_i[c])
						`CHK(tx_char_err_o[c], exp_err(l, m[0], tx_char_i[c]))
						`CHK(rx_parity_oe_o[c], l != 0)
						if (l != 0) `CHK(rx_parity_bit_o[c], exp_par(l, m[0], rx_char_i[c]))
						`CHK(rx_char_bits_o[c], rx_char_i[c].bits)
						`CHK(rx_status_bits_o[c], rx_char_i[c].status)
					end
				end
				`CHK(cdr_serial_o, (sel & primary_serial_in_i) | (~sel & secondary_serial_in_i))
				`CHK(rate_range_select_o, l[1:0])
				rd(pcis_pkg::OFS_RATE, exp_rate(l), pcis_pkg::RESP_OKAY);
			end
		end
		wr(pcis_pkg::OFS_MASK, 32'h1, pcis_pkg::RESP_OKAY);
		step(4'h0);
		wr(pcis_pkg::OFS_STATUS, 32'hf, pcis_pkg::RESP_OKAY);
		`CHK(irq_o, 1'b0)
		step(4'h2);
		`CHK(irq_o, 1'b0)
		rd(pcis_pkg::OFS_STATUS, 32'h2, pcis_pkg::RESP_OKAY);
		step(4'h1);
		`CHK(irq_o, 1'b1)
		step(4'h0);
		wr(pcis_pkg::OFS_STATUS, 32'h1, pcis_pkg::RESP_OKAY);
		rd(pcis_pkg::OFS_STATUS, 32'h2, pcis_pkg::RESP_OKAY);
		`CHK(irq_o, 1'b0)
		wr(pcis_pkg::OFS_CTRL, 32'h0000_0f3a, pcis_pkg::RESP_OKAY);
		step(4'h0);
		`CHK(tx_char_o === tx_char_i, 1'b0)
		{tx_iface_clk_en_i, rx_iface_clk_en_i} <= 2'h3;
		@(posedge clk_i);
		{tx_iface_clk_en_i, rx_iface_clk_en_i} <= 2'h0;
		@(posedge clk_i);
		`CHK(tx_char_o, tx_char_i)
		`CHK(rx_char_bits_o[0], rx_char_i[0].bits)
		report_and_stop();
	end
endmodule
